//--- rtcsf_consts.vh
// Constants for the RTC status, flags and century block.
`ifndef RTCSF_CONSTS_VH
`define RTCSF_CONSTS_VH

// ==========================================================================
// Register word offsets on the Avalon-MM slave (word index, 4 bits).
// ==========================================================================
`define RTCSF_OFS_FLAGS     4'h0
`define RTCSF_OFS_CENTURY   4'h1
`define RTCSF_OFS_ALMSEC    4'h2
`define RTCSF_OFS_IRQ_STAT  4'h3
`define RTCSF_OFS_IRQ_MASK  4'h4
`define RTCSF_OFS_TIME      4'h5
`define RTCSF_OFS_USER      4'h6
`define RTCSF_OFS_INPUTS    4'h7

// ==========================================================================
// Documented byte offsets in the memory map, kept for reference.
// ==========================================================================
`define RTCSF_MAP_FLAGS     20'h1fff0
`define RTCSF_MAP_CENTURY   20'h1fff1

// ==========================================================================
// Flags register fields and the alarm-seconds mask bit.
// ==========================================================================
`define RTCSF_FLG_WDF       7
`define RTCSF_FLG_ALM       6
`define RTCSF_FLG_PWR       5
`define RTCSF_FLG_OSC       4
`define RTCSF_FLG_CAL       2
`define RTCSF_FLG_WFRZ      1
`define RTCSF_FLG_RFRZ      0
`define RTCSF_ALMSEC_MASK   7

// ==========================================================================
// Interrupt status bits.
// ==========================================================================
`define RTCSF_IRQ_ALM       0
`define RTCSF_IRQ_PWR       1
`define RTCSF_IRQ_OSC       2
`define RTCSF_IRQ_WDG       3

// ==========================================================================
// Reset values.
// ==========================================================================
`define RTCSF_RST_BYTE      8'h00
`define RTCSF_RST_IRQ       4'h0

// ==========================================================================
// Timing: clock 250 MHz, oscillator check 5 ms, calibration 512 Hz.
// ==========================================================================
`define RTCSF_CLK_HZ        250000000
`define RTCSF_OSC_CHK_MS    5
`define RTCSF_OSC_CHK_CYC   (`RTCSF_CLK_HZ / 1000 * `RTCSF_OSC_CHK_MS)
`define RTCSF_CAL_HZ        512
`define RTCSF_CAL_HALF_CYC  (`RTCSF_CLK_HZ / (2 * `RTCSF_CAL_HZ))

`endif

//--- rtcsf_div.v
// Gated divider producing a one-cycle enable every HALF cycles while i_run is high.
`timescale 1ns/1ps

module rtcsf_div #(
  parameter [31:0] HALF = 32'd244140
) (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_run,
  output reg  o_tick
);

  reg [31:0] cnt_q;  // Cycles since the last tick.

  // ========================================================================
  // Divider
  // ========================================================================
  // Counts while running, restarts when stopped so a new wave starts clean.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 32'h0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_q  <= 32'h0;
      o_tick <= 1'b0;
    end else if (cnt_q == HALF - 32'h1) begin
      cnt_q  <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
      o_tick <= 1'b0;
    end
  end

endmodule

//--- rtcsf_sync.v
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps

module rtcsf_sync (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_d,
  output wire o_q
);

  reg meta_q;  // First stage, read only by the second stage.
  reg sync_q;  // Second stage, safe for logic.

  // ========================================================================
  // Synchroniser
  // ========================================================================
  // Both stages reset to zero; the first stage feeds only the second.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

//--- rtcsf_top.v
// Status flags, century and alarm-seconds mask block of the RTC.
// Function
// - Seconds mask 1 drops seconds from match.
// - Power-fail flag sets on drop, read clears; here the flag is set again every cycle while the supply stays low.
// - Oscillator not running at 5 ms sets fail.
// - Only software writing 0 clears oscillator-fail.
// - Oscillator-fail flag survives power cycles.
// - Calibration bit 1 drives 512 Hz on interrupt.
// - Calibration bit 0 restores normal interrupt output.
// - Calibration bit comes up zero at power-up.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "rtcsf_consts.vh"

module rtcsf_top #(
  parameter [31:0] OSC_CHK_CYC = `RTCSF_OSC_CHK_CYC
) (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  input  wire        i_supply_low,
  input  wire        i_osc_enabled,
  input  wire        i_osc_running,
  input  wire        i_osc_fail_kept,
  input  wire        i_watchdog_expired,
  input  wire [7:0]  i_time_seconds,
  input  wire        i_other_fields_match,
  output reg         o_int,
  output reg         o_osc_fail_store,
  output reg         o_time_load,
  output reg  [7:0]  o_time_load_seconds
);

  // ========================================================================
  // Declarations
  // ========================================================================
  wire       supply_low_s;     // Synchronised supply-below-threshold.
  wire       osc_running_s;    // Synchronised oscillator activity.
  wire       osc_enabled_s;    // Synchronised oscillator enable.
  wire       osc_kept_s;       // Synchronised retained fail bit.
  wire       wdg_s;            // Synchronised watchdog expiry.
  wire       cal_tick;         // Half period tick of the 512 Hz wave.
  reg  [7:0] flags_q;          // Flags and control register.
  reg  [7:0] century_q;        // Century register, BCD.
  reg  [7:0] almsec_q;         // Alarm seconds with mask bit.
  reg  [7:0] user_sec_q;       // User copy of the seconds.
  reg  [3:0] irq_stat_q;       // Sticky interrupt status.
  reg  [3:0] irq_mask_q;       // Interrupt mask.
  reg  [31:0] chk_q;           // Power-up oscillator check counter.
  reg        chk_done_q;       // Oscillator check finished.
  reg        cal_wave_q;       // Calibration square wave level.
  reg        supply_low_q;     // Last supply level, for edge detection.
  reg        wdg_q;            // Last watchdog level.
  reg        wfrz_q;           // Last write-freeze bit.
  reg        alarm_q;          // Last match level.
  reg        acc_q;            // Access accepted this cycle.
  wire       access;           // Request pending and not yet answered.
  wire       wr;               // Write taking effect.
  wire       rd;               // Read taking effect.
  wire       sec_match;        // Seconds comparison result.
  wire       alarm_hit;        // Whole alarm comparison.
  wire       pwr_rise;         // Supply just fell below threshold.
  wire       wdg_rise;         // Watchdog just expired.
  wire       osc_fail_set;     // Oscillator check failed.
  wire [3:0] irq_ev;           // Events this cycle.

  // Merges a write byte into an old byte under its byte enable.
  function [7:0] merge_byte;
    input [7:0] old_v;
    input [7:0] new_v;
    input       en;
    begin
      merge_byte = en ? new_v : old_v;
    end
  endfunction

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  rtcsf_sync u_sync_sup (.i_clk(i_clk), .i_rst(i_rst),
                         .i_d(i_supply_low), .o_q(supply_low_s));
  rtcsf_sync u_sync_run (.i_clk(i_clk), .i_rst(i_rst),
                         .i_d(i_osc_running), .o_q(osc_running_s));
  rtcsf_sync u_sync_ena (.i_clk(i_clk), .i_rst(i_rst),
                         .i_d(i_osc_enabled), .o_q(osc_enabled_s));
  rtcsf_sync u_sync_kep (.i_clk(i_clk), .i_rst(i_rst),
                         .i_d(i_osc_fail_kept), .o_q(osc_kept_s));
  rtcsf_sync u_sync_wdg (.i_clk(i_clk), .i_rst(i_rst),
                         .i_d(i_watchdog_expired), .o_q(wdg_s));

  // ========================================================================
  // Calibration divider
  // ========================================================================
  // Ticks every half period of 512 Hz while calibration is on.
  rtcsf_div #(
    .HALF(`RTCSF_CAL_HALF_CYC)
  ) u_cal_div (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_run  (flags_q[`RTCSF_FLG_CAL]),
    .o_tick (cal_tick)
  );

  // ========================================================================
  // Bus handshake and event decode
  // ========================================================================
  // Every access takes one wait cycle, then completes with waitrequest low.
  assign access = (i_avs_read | i_avs_write) & ~acc_q;
  assign wr = i_avs_write & acc_q;
  assign rd = i_avs_read & acc_q;
  // Mask 1 ignores seconds; mask 0 compares them.
  assign sec_match = almsec_q[`RTCSF_ALMSEC_MASK] |
                     (almsec_q[6:0] == i_time_seconds[6:0]);
  assign alarm_hit = sec_match & i_other_fields_match;
  assign pwr_rise = supply_low_s & ~supply_low_q;
  assign wdg_rise = wdg_s & ~wdg_q;
  // After 5 ms an enabled oscillator that is not running is a failure.
  assign osc_fail_set = ~chk_done_q & (chk_q == OSC_CHK_CYC - 32'h1) &
                        osc_enabled_s & ~osc_running_s;
  assign irq_ev = {wdg_rise, osc_fail_set, pwr_rise, alarm_hit & ~alarm_q};

  // ========================================================================
  // Bus timing and edge history
  // ========================================================================
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q             <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      supply_low_q      <= 1'b0;
      wdg_q             <= 1'b0;
      alarm_q           <= 1'b0;
    end else begin
      acc_q             <= access;
      o_avs_waitrequest <= ~access;
      supply_low_q      <= supply_low_s;
      wdg_q             <= wdg_s;
      alarm_q           <= alarm_hit;
    end
  end

  // ========================================================================
  // Power-up oscillator check
  // ========================================================================
  // Counts the first 5 ms after reset release, then stops for good.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chk_q      <= 32'h0;
      chk_done_q <= 1'b0;
    end else if (!chk_done_q) begin
      if (chk_q == OSC_CHK_CYC - 32'h1) begin
        chk_done_q <= 1'b1;
      end else begin
        chk_q <= chk_q + 32'h1;
      end
    end
  end

  // ========================================================================
  // Flags register
  // ========================================================================
  // Hardware sets win over clears in the same cycle.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= `RTCSF_RST_BYTE;  // Calibration and freezes off.
    end else begin
      // Read of the flags clears the three event flags.
      if (rd && i_avs_address == `RTCSF_OFS_FLAGS) begin
        flags_q[`RTCSF_FLG_WDF] <= 1'b0;
        flags_q[`RTCSF_FLG_ALM] <= 1'b0;
        flags_q[`RTCSF_FLG_PWR] <= 1'b0;
      end
      // Software controls; the fail flag may only be written to 0.
      if (wr && i_avs_address == `RTCSF_OFS_FLAGS &&
          i_avs_byteenable[0]) begin
        flags_q[2:0] <= i_avs_writedata[2:0];
        if (!i_avs_writedata[`RTCSF_FLG_OSC]) begin
          flags_q[`RTCSF_FLG_OSC] <= 1'b0;
        end
      end
      // The retained copy restores the fail flag after power-up.
      if (osc_kept_s) begin
        flags_q[`RTCSF_FLG_OSC] <= 1'b1;
      end
      if (osc_fail_set) begin
        flags_q[`RTCSF_FLG_OSC] <= 1'b1;
      end
      if (pwr_rise || supply_low_s) begin
        flags_q[`RTCSF_FLG_PWR] <= 1'b1;
      end
      if (irq_ev[`RTCSF_IRQ_ALM]) begin
        flags_q[`RTCSF_FLG_ALM] <= 1'b1;
      end
      if (wdg_rise) begin
        flags_q[`RTCSF_FLG_WDF] <= 1'b1;
      end
      flags_q[3] <= 1'b0;
    end
  end

  // ========================================================================
  // Century, alarm seconds and user seconds copy
  // ========================================================================
  // Writes are honoured always; the time copy pauses while frozen.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      century_q  <= `RTCSF_RST_BYTE;
      almsec_q   <= `RTCSF_RST_BYTE;
      user_sec_q <= `RTCSF_RST_BYTE;
    end else begin
      if (wr && i_avs_address == `RTCSF_OFS_CENTURY) begin
        century_q <= merge_byte(century_q, i_avs_writedata[7:0],
                                i_avs_byteenable[0]);
      end
      if (wr && i_avs_address == `RTCSF_OFS_ALMSEC) begin
        almsec_q <= merge_byte(almsec_q, i_avs_writedata[7:0],
                               i_avs_byteenable[0]);
      end
      if (wr && i_avs_address == `RTCSF_OFS_USER) begin
        user_sec_q <= merge_byte(user_sec_q, i_avs_writedata[7:0],
                                 i_avs_byteenable[0]);
      end else if (!flags_q[`RTCSF_FLG_WFRZ] &&
                   !flags_q[`RTCSF_FLG_RFRZ]) begin
        user_sec_q <= i_time_seconds;
      end
    end
  end

  // ========================================================================
  // Transfer to timekeeper and retained-flag output
  // ========================================================================
  // Dropping write freeze loads the user copy into the timekeeper.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wfrz_q              <= 1'b0;
      o_time_load         <= 1'b0;
      o_time_load_seconds <= 8'h00;
      o_osc_fail_store    <= 1'b0;
    end else begin
      wfrz_q              <= flags_q[`RTCSF_FLG_WFRZ];
      o_time_load         <= wfrz_q & ~flags_q[`RTCSF_FLG_WFRZ];
      o_time_load_seconds <= user_sec_q;
      o_osc_fail_store    <= flags_q[`RTCSF_FLG_OSC];
    end
  end

  // ========================================================================
  // Interrupt status and mask
  // ========================================================================
  // Write one to clear; a new event in the same cycle wins.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= `RTCSF_RST_IRQ;
      irq_mask_q <= `RTCSF_RST_IRQ;
    end else begin
      if (wr && i_avs_address == `RTCSF_OFS_IRQ_STAT &&
          i_avs_byteenable[0]) begin
        irq_stat_q <= (irq_stat_q & ~i_avs_writedata[3:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (wr && i_avs_address == `RTCSF_OFS_IRQ_MASK &&
          i_avs_byteenable[0]) begin
        irq_mask_q <= i_avs_writedata[3:0];
      end
    end
  end

  // ========================================================================
  // Interrupt pin: calibration wave or masked status
  // ========================================================================
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_wave_q <= 1'b0;
      o_int      <= 1'b0;
    end else begin
      if (!flags_q[`RTCSF_FLG_CAL]) begin
        cal_wave_q <= 1'b0;
        o_int      <= |(irq_stat_q & irq_mask_q);
      end else begin
        if (cal_tick) begin
          cal_wave_q <= ~cal_wave_q;
        end
        o_int <= cal_wave_q;
      end
    end
  end

  // ========================================================================
  // Read data
  // ========================================================================
  // Unmapped offsets read as zero.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0;
    end else if (access && i_avs_read) begin
      case (i_avs_address)
        `RTCSF_OFS_FLAGS:    o_avs_readdata <= {24'h0, flags_q};
        `RTCSF_OFS_CENTURY:  o_avs_readdata <= {24'h0, century_q};
        `RTCSF_OFS_ALMSEC:   o_avs_readdata <= {24'h0, almsec_q};
        `RTCSF_OFS_IRQ_STAT: o_avs_readdata <= {28'h0, irq_stat_q};
        `RTCSF_OFS_IRQ_MASK: o_avs_readdata <= {28'h0, irq_mask_q};
        `RTCSF_OFS_TIME:     o_avs_readdata <= {24'h0, i_time_seconds};
        `RTCSF_OFS_USER:     o_avs_readdata <= {24'h0, user_sec_q};
        `RTCSF_OFS_INPUTS:   o_avs_readdata <= {28'h0, chk_done_q,
                                                supply_low_s, osc_running_s,
                                                osc_enabled_s};
        default:             o_avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule

//--- rtcsf_top_bench.sv
// Self-checking testbench for the RTC status, flags and century block.
`timescale 1ns/1ps
module rtcsf_top_bench;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        rd = 1'b0, wr = 1'b0, sup = 1'b0, oen = 1'b1, orun = 1'b1;
  logic        okept = 1'b0, wdog = 1'b0, omatch = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [7:0]  secs = 8'h00, s, v, load_val;
  logic        wreq, intr, ostore, tload, load_seen;
  logic [7:0]  tsecs;
  int          num_errors = 0;
  int          check_count = 0;
  int          r;
  always #2 i_clk = ~i_clk;
  rtcsf_top #(.OSC_CHK_CYC(32'd50)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_supply_low(sup), .i_osc_enabled(oen),
    .i_osc_running(orun), .i_osc_fail_kept(okept),
    .i_watchdog_expired(wdog), .i_time_seconds(secs),
    .i_other_fields_match(omatch), .o_int(intr), .o_osc_fail_store(ostore),
    .o_time_load(tload), .o_time_load_seconds(tsecs));
  // Catches the one-cycle transfer pulse and the seconds it carries.
  always @(posedge i_clk) if (tload === 1'b1) begin
    load_seen <= 1'b1;
    load_val  <= tsecs;
  end
  // ==========================================================
  // Tasks and expectation helpers.
  // ==========================================================
  task summarize;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One Avalon access held until waitrequest is seen low.
  task bus(input logic w, input logic [3:0] a, input logic [7:0] val);
    int n;
    n = 0;
    adr <= a;
    wd  <= {24'h0, val};
    wr  <= w;
    rd  <= !w;
    @(posedge i_clk);
    while (wreq !== 1'b0) begin
      n++;
      if (n > 20) begin
        num_errors++;
        summarize;
      end
      @(posedge i_clk);
    end
    d = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
             input string s);
    bus(1'b0, a, 8'h00);
    check(d & m, e, s);
  endtask
  task do_reset;
    i_rst <= 1'b1;
    cyc(5);
    i_rst <= 1'b0;
    cyc(1);
  endtask
  // Alarm fires when seconds agree or the seconds mask is set.
  function automatic logic [31:0] alarm_exp(input bit m, input bit eq);
    return (m || eq) ? 32'h40 : 32'h0;
  endfunction
  // Guards against a hung run.
  initial begin
    cyc(50000);
    num_errors++;
    summarize;
  end
  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial begin
    r = $urandom(34);
    do_reset;
    cyc(60);
    rdchk(4'h0, 32'h14, 32'h0, "osc ok, cal off");
    oen  <= 1'b0;
    orun <= 1'b0;
    do_reset;
    cyc(60);
    rdchk(4'h0, 32'h10, 32'h0, "osc disabled, no fail");
    oen  <= 1'b1;
    do_reset;
    cyc(60);
    rdchk(4'h0, 32'h10, 32'h10, "osc fail set");
    check({31'h0, ostore}, 32'h1, "fail store");
    bus(1'b1, 4'h0, 8'h10);
    rdchk(4'h0, 32'h10, 32'h10, "write one ignored");
    bus(1'b1, 4'h0, 8'h00);
    cyc(60);
    rdchk(4'h0, 32'h10, 32'h0, "write zero clears");
    okept <= 1'b1;
    cyc(8);
    bus(1'b1, 4'h0, 8'h00);
    rdchk(4'h0, 32'h10, 32'h10, "kept copy restores");
    okept <= 1'b0;
    orun  <= 1'b1;
    cyc(4);
    bus(1'b1, 4'h0, 8'h00);
    $display("end test oscillator");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'h2, {i[1], 7'h25});
      secs <= i[0] ? 8'h25 : 8'h26;
      bus(1'b0, 4'h0, 8'h00);
      omatch <= 1'b1;
      cyc(5);
      rdchk(4'h0, 32'h40, alarm_exp(i[1], i[0]), "alarm");
      omatch <= 1'b0;
      cyc(2);
    end
    $display("end test alarm");
    bus(1'b1, 4'h4, 8'h02);
    sup <= 1'b1;
    wdog <= 1'b1;
    cyc(6);
    rdchk(4'h0, 32'ha0, 32'ha0, "power and watchdog set");
    check({31'h0, intr}, 32'h1, "irq raised");
    sup <= 1'b0;
    wdog <= 1'b0;
    cyc(6);
    rdchk(4'h0, 32'ha0, 32'h20, "power fail kept till read");
    rdchk(4'h0, 32'ha0, 32'h0, "read clears");
    bus(1'b1, 4'h0, 8'h04);
    cyc(4);
    check({31'h0, intr}, 32'h0, "wave replaces irq");
    rdchk(4'h0, 32'h0c, 32'h04, "cal bit set");
    bus(1'b1, 4'h0, 8'h00);
    cyc(4);
    check({31'h0, intr}, 32'h1, "irq back");
    bus(1'b1, 4'h4, 8'h00);
    cyc(3);
    check({31'h0, intr}, 32'h0, "irq masked");
    bus(1'b1, 4'h4, 8'h02);
    bus(1'b1, 4'h3, 8'h02);
    cyc(3);
    check({31'h0, intr}, 32'h0, "irq cleared");
    rdchk(4'h3, 32'h2, 32'h0, "status cleared");
    $display("end test interrupt");
    s = $urandom;
    v = $urandom;
    secs <= s;
    bus(1'b1, 4'h0, 8'h02);
    bus(1'b1, 4'h6, v);
    secs <= s + 8'h01;
    cyc(4);
    rdchk(4'h6, 32'hff, {24'h0, v}, "frozen user copy");
    load_seen <= 1'b0;
    bus(1'b1, 4'h0, 8'h00);
    cyc(4);
    check({31'h0, load_seen}, 32'h1, "transfer pulse");
    check({24'h0, load_val}, {24'h0, v}, "transfer value");
    rdchk(4'h6, 32'hff, {24'h0, s + 8'h01}, "copy follows");
    bus(1'b1, 4'h0, 8'h01);
    secs <= s + 8'h07;
    cyc(4);
    rdchk(4'h6, 32'hff, {24'h0, s + 8'h01}, "read snapshot");
    bus(1'b1, 4'h0, 8'h00);
    cyc(4);
    rdchk(4'h6, 32'hff, {24'h0, s + 8'h07}, "updates resume");
    $display("end test freeze");
    v = $urandom;
    bus(1'b1, 4'h1, v);
    rdchk(4'h1, 32'hffffffff, {24'h0, v}, "century");
    rdchk(4'h2, 32'hff, 32'ha5, "alarm seconds");
    rdchk(4'h7, 32'hf, 32'hb, "inputs");
    rdchk(4'h5, 32'hffffffff, {24'h0, s + 8'h07}, "live seconds");
    rdchk(4'h8, 32'hffffffff, 32'h0, "unmapped");
    $display("end test registers");
    summarize;
  end
endmodule

//--- rtcsf_top_properties.sv
// Port-level assertions for the RTC status, flags and century block.
`timescale 1ns/1ps
module rtcsf_props #(
  parameter [31:0] OSC_CHK_CYC = 32'd50
) (
  input wire        i_clk,
  input wire        i_rst,
  input wire [3:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0]  i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire        i_supply_low,
  input wire        i_osc_fail_kept,
  input wire        o_time_load,
  input wire [7:0]  o_time_load_seconds,
  input wire        o_osc_fail_store
);
  // ==========================================================
  // Shadows of the flags bits and short windows after writes.
  // ==========================================================
  wire       acc_wr = i_avs_write && !o_avs_waitrequest;
  wire       acc_rd = i_avs_read && !o_avs_waitrequest;
  wire       flg_rd = acc_rd && (i_avs_address == 4'h0);
  wire       flg_wr = acc_wr && (i_avs_address == 4'h0) && i_avs_byteenable[0];
  wire [7:0] wd     = i_avs_writedata[7:0];
  reg        cal_q, wfz_q, rfz_q, rdok_q;
  reg  [2:0] clr_q, rel_q, frz_q;
  reg  [3:0] age_q;
  // Age counters and shadows; the read-clear check trusts only quiet reads.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {cal_q, wfz_q, rfz_q, clr_q, rel_q, frz_q} <= 12'h000;
      rdok_q <= 1'b1;
      age_q  <= 4'hf;
    end else begin
      if (flg_wr) {cal_q, wfz_q, rfz_q} <= {wd[2], wd[1], wd[0]};
      clr_q <= (flg_wr && !wd[4]) ? 3'h4 : clr_q - (clr_q != 3'h0);
      rel_q <= (flg_wr && wfz_q && !wd[1]) ? 3'h4 : rel_q - (rel_q != 3'h0);
      frz_q <= ((wfz_q || rfz_q) && !(acc_wr && i_avs_address == 4'h6)) ?
               frz_q + (frz_q != 3'h7) : 3'h0;
      age_q <= i_supply_low ? 4'h0 : age_q + (age_q != 4'hf);
      if (i_supply_low) rdok_q <= 1'b0;
      else if (flg_rd) rdok_q <= (age_q > 4'h4);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("late answer");
  a_oscillator_fail_flag_sw_clear: assert property (
    $fell(o_osc_fail_store) |-> clr_q != 3'h0) else $error("osc fail lost");
  a_oscillator_fail_flag_retained: assert property (
    i_osc_fail_kept [*6] |-> o_osc_fail_store) else $error("kept not set");
  a_pf_read_clear: assert property (
    flg_rd && rdok_q && age_q > 4'h4 |-> !o_avs_readdata[5])
    else $error("power fail not cleared by read");
  a_cal_readback: assert property (
    flg_rd |-> o_avs_readdata[2] == cal_q) else $error("cal bit wrong");
  a_frz_readback: assert property (
    flg_rd |-> o_avs_readdata[1:0] == {wfz_q, rfz_q})
    else $error("freeze bits wrong");
  a_load_on_release: assert property (
    flg_wr && wfz_q && !wd[1] |-> ##[1:3] o_time_load)
    else $error("no transfer on release");
  a_load_cause: assert property (
    $rose(o_time_load) |-> rel_q != 3'h0) else $error("stray transfer");
  a_load_single: assert property (
    o_time_load |=> !o_time_load) else $error("transfer pulse too long");
  a_frz_hold: assert property (
    frz_q >= 3'h3 |-> $stable(o_time_load_seconds))
    else $error("user copy moved while frozen");
  c_release: cover property (flg_wr && wfz_q && !wd[1]);
  c_osc_fail: cover property ($rose(o_osc_fail_store));
  c_pf_read: cover property (flg_rd && o_avs_readdata[5]);
endmodule

bind rtcsf_top rtcsf_props #(.OSC_CHK_CYC(OSC_CHK_CYC)) u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_supply_low(i_supply_low), .i_osc_fail_kept(i_osc_fail_kept),
  .o_time_load(o_time_load), .o_time_load_seconds(o_time_load_seconds),
  .o_osc_fail_store(o_osc_fail_store));
